// ### shared/goc_pkg.sv
// Shared constants and helpers for the gain and offset correction stage
package goc_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_W = 24;
  localparam int EXP_W = 5;
  localparam int PROD_W = 2 * DATA_W;
  // Divide by full scale done as a shift plus two correction terms
  localparam int DIV_SHIFT = DATA_W - 1;

  // ==========================================================
  // Codes and reset values
  localparam logic [DATA_W-1:0] SMP_MAX = 24'h7fffff;
  localparam logic [DATA_W-1:0] SMP_MIN = 24'h800000;
  localparam logic [DATA_W-1:0] GAIN_RST = 24'h7fffff;
  localparam logic [DATA_W-1:0] OFFSET_RST = 24'h000000;
  localparam logic [EXP_W-1:0] EXP_MAX = 5'h18;

  // ==========================================================
  // Clamp a 26-bit signed value into the 24-bit sample range
  function automatic logic [DATA_W-1:0] sat24(input logic signed [DATA_W+1:0] v);
    logic signed [DATA_W+1:0] hi;
    logic signed [DATA_W+1:0] lo;
    hi = {2'b00, SMP_MAX};
    lo = {2'b11, SMP_MIN};
    if (v > hi) begin
      sat24 = SMP_MAX;
    end else if (v < lo) begin
      sat24 = SMP_MIN;
    end else begin
      sat24 = v[DATA_W-1:0];
    end
  endfunction

endpackage

// ### verilog/goc_scale.sv
// Gain scaling stage: sample times gain word over positive full scale
`timescale 1ns/100ps
module goc_scale #(
  parameter int W = goc_pkg::DATA_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Incoming sample
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  // Gain control
  input wire logic i_enable,
  input wire logic [W-1:0] i_gain,
  // Scaled sample
  output logic o_valid,
  output logic [W-1:0] o_data
);

  // ==========================================================
  // Datapath
  localparam int PW = 2 * W;
  localparam logic signed [PW-1:0] ONE = PW'(1);

  wire logic signed [PW-1:0] prod;
  wire logic signed [PW-1:0] quot_sum;
  wire logic signed [W+1:0] quot;
  wire logic [W-1:0] scaled;
  wire logic [W-1:0] data_nxt;

  // (p + p/2^23 + 1) / 2^23 is exact at unity gain, no divider needed
  assign prod = $signed(i_data) * $signed(i_gain);
  assign quot_sum = prod + (prod >>> goc_pkg::DIV_SHIFT) + ONE;
  // Part-selects are unsigned, so the sign is extended by hand
  assign quot = {quot_sum[PW-1], quot_sum[PW-1:goc_pkg::DIV_SHIFT]};
  assign scaled = goc_pkg::sat24(quot);
  assign data_nxt = i_enable ? scaled : i_data;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_data <= '0;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        o_data <= data_nxt;
      end
    end
  end

  // ==========================================================
  // Checks
  wire logic [W:0] in_mag;
  wire logic [W:0] out_mag;
  assign in_mag = i_data[W-1] ? -{1'b1, i_data} : {1'b0, i_data};
  assign out_mag = o_data[W-1] ? -{1'b1, o_data} : {1'b0, o_data};

  property p_unity_gain;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_enable && i_gain == goc_pkg::SMP_MAX) |=> o_data == $past(i_data);
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("unity gain altered");

  property p_gain_reduces;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_enable && i_gain != goc_pkg::SMP_MIN) |=> out_mag <= $past(in_mag);
  endproperty
  a_gain_reduces: assert property (p_gain_reduces) else $error("gain grew sample");

  property p_zero_gain;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_valid && i_enable && i_gain == '0) |=> o_data == '0;
  endproperty
  a_zero_gain: assert property (p_zero_gain) else $error("zero gain nonzero out");

  c_gain_used: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_valid && i_enable && i_gain != goc_pkg::SMP_MAX);

endmodule

// ### verilog/goc_top.sv
// Output-stage gain and offset correction with offset calibration loop
//
// Functional notes
// - Gain and offset words: full 24-bit signed range.
// - Host writes kept and applied exactly.
// - Gain enable scales samples by gain/0x7FFFFF.
// - Offset enable subtracts offset word from sample.
// - Calibration enable starts loop, exponent 0..0x18.
// - Running calibration updates offset word automatically.
// - Disabling calibration keeps last offset result.
`timescale 1ns/100ps
module goc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Filtered sample stream
  input wire logic i_smp_valid,
  input wire logic [goc_pkg::DATA_W-1:0] i_smp_data,
  // Correction word writes from the register port
  input wire logic i_gain_wr,
  input wire logic [goc_pkg::DATA_W-1:0] i_gain_data,
  input wire logic i_offset_wr,
  input wire logic [goc_pkg::DATA_W-1:0] i_offset_data,
  // Control settings
  input wire logic i_gain_correct_enable,
  input wire logic i_offset_correct_enable,
  input wire logic i_offset_cal_enable,
  input wire logic [goc_pkg::EXP_W-1:0] i_cal_feedback_exponent,
  // Corrected sample stream
  output logic o_smp_valid,
  output logic [goc_pkg::DATA_W-1:0] o_smp_data,
  // Register read-back
  output logic [goc_pkg::DATA_W-1:0] o_gain_scale_word,
  output logic [goc_pkg::DATA_W-1:0] o_offset_correction_word,
  output logic o_cal_active
);

  localparam int DW = goc_pkg::DATA_W;

  // ==========================================================
  // Correction words
  logic [DW-1:0] gain_scale_word_r;
  logic [DW-1:0] offset_correction_word_r;
  logic [DW-1:0] offset_nxt;
  logic cal_active_r;

  // ==========================================================
  // Offset subtraction
  wire logic signed [DW+1:0] smp_ext;
  wire logic signed [DW+1:0] off_ext;
  wire logic signed [DW+1:0] diff;
  wire logic [DW-1:0] diff_sat;
  wire logic diff_clipped;
  wire logic [DW-1:0] stage1_nxt;

  assign smp_ext = {{2{i_smp_data[DW-1]}}, i_smp_data};
  assign off_ext = {{2{offset_correction_word_r[DW-1]}}, offset_correction_word_r};
  assign diff = smp_ext - off_ext;
  assign diff_sat = goc_pkg::sat24(diff);
  assign diff_clipped = diff_sat != diff[DW-1:0];
  assign stage1_nxt = i_offset_correct_enable ? diff_sat : i_smp_data;

  // ==========================================================
  // Calibration loop
  // Shift above the top code would zero the step; clamp instead
  wire logic [goc_pkg::EXP_W-1:0] exp_eff;
  wire logic signed [DW+1:0] cal_step;
  wire logic signed [DW+1:0] cal_sum;
  wire logic [DW-1:0] cal_result;
  wire logic cal_update;

  assign exp_eff = (i_cal_feedback_exponent > goc_pkg::EXP_MAX) ?
                   goc_pkg::EXP_MAX : i_cal_feedback_exponent;
  // Step toward the input DC level; larger exponent settles slower
  assign cal_step = diff >>> exp_eff;
  assign cal_sum = off_ext + cal_step;
  assign cal_result = goc_pkg::sat24(cal_sum);
  assign cal_update = i_offset_cal_enable && i_smp_valid;

  // Host write takes priority over a same-cycle calibration step
  always_comb begin
    offset_nxt = offset_correction_word_r;
    if (i_offset_wr) begin
      offset_nxt = i_offset_data;
    end else if (cal_update) begin
      offset_nxt = cal_result;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gain_scale_word_r <= goc_pkg::GAIN_RST;
      offset_correction_word_r <= goc_pkg::OFFSET_RST;
      cal_active_r <= 1'b0;
    end else begin
      if (i_gain_wr) begin
        gain_scale_word_r <= i_gain_data;
      end
      offset_correction_word_r <= offset_nxt;
      cal_active_r <= i_offset_cal_enable;
    end
  end

  // ==========================================================
  // Pipeline: offset stage, then gain stage
  logic stage1_valid_r;
  logic [DW-1:0] stage1_data_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1_valid_r <= 1'b0;
      stage1_data_r <= '0;
    end else begin
      stage1_valid_r <= i_smp_valid;
      if (i_smp_valid) begin
        stage1_data_r <= stage1_nxt;
      end
    end
  end

  goc_scale #(
    .W(DW)
  ) u_scale (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(stage1_valid_r),
    .i_data(stage1_data_r),
    .i_enable(i_gain_correct_enable),
    .i_gain(gain_scale_word_r),
    .o_valid(o_smp_valid),
    .o_data(o_smp_data)
  );

  assign o_gain_scale_word = gain_scale_word_r;
  assign o_offset_correction_word = offset_correction_word_r;
  assign o_cal_active = cal_active_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_gain_load;
    i_gain_wr |=> gain_scale_word_r == $past(i_gain_data);
  endproperty
  a_gain_load: assert property (p_gain_load) else $error("gain word not loaded");

  property p_gain_hold;
    !i_gain_wr |=> $stable(gain_scale_word_r);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain word drifted");

  property p_offset_load;
    i_offset_wr |=> offset_correction_word_r == $past(i_offset_data);
  endproperty
  a_offset_load: assert property (p_offset_load) else $error("offset write lost");

  property p_cal_update;
    (cal_update && !i_offset_wr) |=> offset_correction_word_r == $past(cal_result);
  endproperty
  a_cal_update: assert property (p_cal_update) else $error("no calibration step");

  property p_cal_keep;
    (!i_offset_cal_enable && !i_offset_wr) |=> $stable(offset_correction_word_r);
  endproperty
  a_cal_keep: assert property (p_cal_keep) else $error("offset lost after cal");

  // Top exponent and above: the step is at most one code downward
  property p_exp_range;
    (cal_update && !i_offset_wr && i_cal_feedback_exponent >= goc_pkg::EXP_MAX) |=>
      offset_correction_word_r == $past(offset_correction_word_r) ||
      offset_correction_word_r == $past(offset_correction_word_r) - 24'h000001;
  endproperty
  a_exp_range: assert property (p_exp_range) else $error("exponent out of range");

  property p_offset_sub;
    (i_smp_valid && i_offset_correct_enable && !diff_clipped) |=>
      stage1_data_r == $past(i_smp_data - offset_correction_word_r);
  endproperty
  a_offset_sub: assert property (p_offset_sub) else $error("offset not subtracted");

  property p_bypass;
    (i_smp_valid && !i_offset_correct_enable) ##1 !i_gain_correct_enable |=>
      o_smp_valid && o_smp_data == $past(i_smp_data, 2);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered sample");

  property p_latency;
    i_smp_valid |-> ##2 o_smp_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("output not two cycles later");

  property p_no_spurious;
    !i_smp_valid |-> ##2 !o_smp_valid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("output without input");

  // Exponent zero: one step lands the offset on the sample itself
  property p_cal_full_step;
    (cal_update && !i_offset_wr && i_cal_feedback_exponent == '0) |=>
      offset_correction_word_r == $past(i_smp_data);
  endproperty
  a_cal_full_step: assert property (p_cal_full_step) else $error("bad full step");

  property p_cal_flag;
    1'b1 |=> o_cal_active == $past(i_offset_cal_enable);
  endproperty
  a_cal_flag: assert property (p_cal_flag) else $error("cal flag wrong");

  property p_out_hold;
    !stage1_valid_r |=> $stable(o_smp_data);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved");

  // Clipped difference must pin to the rail of its own sign
  property p_clip_sat;
    (i_smp_valid && i_offset_correct_enable && diff_clipped) |=>
      stage1_data_r == ($past(diff[DW+1]) ? goc_pkg::SMP_MIN : goc_pkg::SMP_MAX);
  endproperty
  a_clip_sat: assert property (p_clip_sat) else $error("clipped sample wrong");

  c_cal_run: cover property (cal_update [*4]);
  c_cal_stop: cover property (cal_active_r && !i_offset_cal_enable);
  c_both_on: cover property (i_smp_valid && i_offset_correct_enable && i_gain_correct_enable);
  c_clip: cover property (i_smp_valid && i_offset_correct_enable && diff_clipped);

endmodule

// ### verification/goc_host.sv
// Host model that writes correction words and control settings
`timescale 1ns/100ps
module goc_host (
  // Clock
  input wire logic i_clk,
  // Correction word writes
  output logic o_gain_wr,
  output logic [goc_pkg::DATA_W-1:0] o_gain_data,
  output logic o_offset_wr,
  output logic [goc_pkg::DATA_W-1:0] o_offset_data,
  // Control settings
  output logic o_gain_en,
  output logic o_offset_en,
  output logic o_cal_en,
  output logic [goc_pkg::EXP_W-1:0] o_exp
);
  initial begin
    {o_gain_wr, o_offset_wr, o_gain_en, o_offset_en, o_cal_en} = 5'h00;
    {o_gain_data, o_offset_data, o_exp} = '0;
  end

  // Whole word in one strobe; released data is inverted so stale values never look valid
  task automatic write(input bit g, input logic [goc_pkg::DATA_W-1:0] v);
    @(posedge i_clk);
    #1;
    if (g) begin
      o_gain_wr = 1'b1;
      o_gain_data = v;
    end else begin
      o_offset_wr = 1'b1;
      o_offset_data = v;
    end
    @(posedge i_clk);
    #1;
    {o_gain_wr, o_offset_wr} = 2'b00;
    o_gain_data = ~o_gain_data;
    o_offset_data = ~o_offset_data;
  endtask

  task automatic ctrl(input bit g, input bit o, input bit c, input logic [4:0] e);
    @(posedge i_clk);
    #1;
    {o_gain_en, o_offset_en, o_cal_en, o_exp} = {g, o, c, e};
  endtask
endmodule

// ### verification/gain_offset_correction_test.sv
// Self-checking bench for the gain and offset correction stage
`timescale 1ns/100ps
module gain_offset_correction_test;
  logic i_clk, i_rst_n, sv, ov, gw, ow, ge, oe, ce, cact;
  logic [23:0] sd, odat, gd, od, gword, oword;
  logic [4:0] ex;
  int n_fail = 0;
  int n_checks = 0;
  integer seed = 32'h2d6235e2;
  longint m_gain, m_off, q[$];
  longint vals[3];

  goc_host host (.i_clk(i_clk), .o_gain_wr(gw), .o_gain_data(gd), .o_offset_wr(ow),
    .o_offset_data(od), .o_gain_en(ge), .o_offset_en(oe), .o_cal_en(ce), .o_exp(ex));
  goc_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_smp_valid(sv), .i_smp_data(sd),
    .i_gain_wr(gw), .i_gain_data(gd), .i_offset_wr(ow), .i_offset_data(od),
    .i_gain_correct_enable(ge), .i_offset_correct_enable(oe), .i_offset_cal_enable(ce),
    .i_cal_feedback_exponent(ex), .o_smp_valid(ov), .o_smp_data(odat),
    .o_gain_scale_word(gword), .o_offset_correction_word(oword), .o_cal_active(cact));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  function automatic longint sx(logic [23:0] v);
    return $signed(v);
  endfunction

  function automatic longint sat(longint v);
    return v > 8388607 ? 8388607 : v < -8388608 ? -8388608 : v;
  endfunction

  function automatic longint rnd();
    logic [23:0] r;
    r = 24'($random(seed));
    return sx(r);
  endfunction

  // Reference model: offset first, then gain over full scale
  function automatic longint expect_out(longint x);
    longint s, p;
    s = oe ? sat(x - m_off) : x;
    if (ge) begin
      p = s * m_gain;
      s = sat((p + (p >>> 23) + 1) >>> 23);
    end
    return s;
  endfunction

  task automatic chk(string nm, longint e, logic [23:0] g);
    n_checks++;
    if (g !== e[23:0]) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e[23:0], g);
    end
  endtask

  always @(negedge i_clk) begin
    if (ov === 1'b1 && q.size() > 0) chk("sample", q.pop_front(), odat);
    else if (ov !== 1'b0 && i_rst_n) chk("stray valid", 0, {23'h0, ov});
  end

  // Back-to-back samples, starting with both extremes of the code range
  task automatic burst(int n);
    longint x;
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      #1;
      x = k == 0 ? -8388608 : k == 1 ? 8388607 : rnd();
      sv = 1'b1;
      sd = x[23:0];
      q.push_back(expect_out(x));
      if (ce) m_off = sat(m_off + ((x - m_off) >>> (ex > 24 ? 24 : ex)));
    end
    @(posedge i_clk);
    #1;
    sv = 1'b0;
    sd = ~sd;
    chk("offset word", m_off, oword);
    chk("cal active", longint'(ce), {23'h0, cact});
    repeat (3) @(posedge i_clk);
    chk("pending", 0, 24'(q.size()));
  endtask

  task automatic wr(bit g, longint v);
    host.write(g, v[23:0]);
    if (g) m_gain = v;
    else m_off = v;
    chk("gain word", m_gain, gword);
    chk("offset word", m_off, oword);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    {i_rst_n, sv, sd} = '0;
    m_gain = 8388607;
    m_off = 0;
    repeat (20) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    chk("gain reset", m_gain, gword);
    chk("offset reset", 0, oword);
    chk("valid reset", 0, {23'h0, ov});
    $display("test reset done");
    burst(12);
    $display("test pass-through done");
    vals = '{-8388608, 8388607, rnd()};
    foreach (vals[i]) begin
      wr(1'b1, vals[i]);
      wr(1'b0, vals[i]);
    end
    $display("test words done");
    wr(1'b0, rnd());
    host.ctrl(1'b0, 1'b1, 1'b0, 5'h00);
    burst(12);
    wr(1'b0, 8388607);
    burst(6);
    $display("test offset done");
    vals = '{0, -8388608, 4194304};
    for (int k = 0; k < 5; k++) begin
      wr(1'b1, k < 3 ? vals[k] : k == 3 ? 8388607 : rnd());
      host.ctrl(1'b1, k[0], 1'b0, 5'h00);
      burst(8);
    end
    $display("test gain done");
    wr(1'b1, 8388607);
    foreach (vals[i]) begin
      host.ctrl(1'b0, 1'b1, 1'b1, i == 0 ? 5'h00 : i == 1 ? 5'h05 : 5'h18);
      burst(10);
    end
    host.ctrl(1'b1, 1'b1, 1'b1, 5'h1f);
    burst(10);
    $display("test calibration done");
    host.ctrl(1'b0, 1'b1, 1'b0, 5'h18);
    burst(8);
    $display("test keep done");
    give_verdict();
  end
endmodule
